// ### battery_fault_supervisor.sv
`timescale 1ns/100ps

module battery_fault_supervisor #(
    parameter int unsigned CYCLES_PER_SEC = supervisor_pkg::CYCLES_PER_SEC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    input wire supervisor_pkg::comp_t comp_i,
    input wire logic [9:0] adc_result,
    output supervisor_pkg::status_t fault_status_word,
    output logic battery_drain_drive,
    output logic charge_loop_enable,
    output logic gas_gauge_enable,
    output logic analog_power_on,
    output logic [7:0] loop_ref_mv
);

    ////////////////////////////////////////////////////////////////////////
    supervisor_pkg::state_t q;
    supervisor_pkg::state_t d;
    logic ck_rise;
    logic ck_fall;
    logic cs_high;
    logic [4:0] nb;
    logic [1:0] mode;
    logic [1:0] ref_code;
    logic [2:0] to_code;
    logic [supervisor_pkg::MIN_W-1:0] limit;
    logic dis_mode;
    logic chg_mode;
    logic clr;
    logic dis_fault;
    logic chg_fault;
    logic fs_set;
    logic hit;

    assign ck_rise = q.ck_s2 & ~q.ck_prev;
    assign ck_fall = ~q.ck_s2 & q.ck_prev;
    assign cs_high = q.cs_s2;
    assign nb = q.bit_cnt + supervisor_pkg::BIT_ONE;
    assign mode = {q.cmd.operating_select_hi, q.cmd.operating_select_lo};
    assign ref_code = {q.cmd.loop_ref_sel_hi, q.cmd.loop_ref_sel_lo};
    assign to_code = {q.cmd.timeout_sel_bit2, q.cmd.timeout_sel_bit1, q.cmd.timeout_sel_bit0};
    assign limit = supervisor_pkg::TIMEOUT_BASE_MIN << to_code;
    assign clr = q.cmd.failsafe_clear_bit;
    assign dis_mode = (mode == supervisor_pkg::MODE_DRAIN) & ~q.cmd.power_shutdown_bit;
    assign chg_mode = (mode == supervisor_pkg::MODE_CHARGE) & ~q.cmd.power_shutdown_bit;
    // fault terms come from synchronised status, valid in every mode
    assign dis_fault = q.status.end_discharge_flag | q.status.under_temperature_flag
                     | q.status.over_temperature_flag | q.status.charge_time_expired_flag;
    assign chg_fault = q.status.max_cell_voltage_flag | q.status.under_temperature_flag
                     | q.status.over_temperature_flag | q.status.charge_time_expired_flag;
    assign fs_set = (dis_mode & dis_fault) | (chg_mode & chg_fault);
    assign hit = (to_code != supervisor_pkg::TO_NONE) & (q.min_cnt >= limit);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        // input synchronisers: stage one feeds stage two only
        d.cs_s1 = cs_n;
        d.cs_s2 = q.cs_s1;
        d.ck_s1 = sclk;
        d.ck_s2 = q.ck_s1;
        d.ck_prev = q.ck_s2;
        d.di_s1 = din;
        d.di_s2 = q.di_s1;
        d.comp_s1 = comp_i;
        d.comp_s2 = q.comp_s1;

        // live comparator bits of the status word
        d.status.battery_present_flag = q.comp_s2.vbat_below_present;
        d.status.battery_reversed_flag = q.comp_s2.cell_below_reverse;
        d.status.max_cell_voltage_flag = q.comp_s2.cell_above_max;
        d.status.end_discharge_flag = q.comp_s2.cell_below_end;
        d.status.over_temperature_flag = q.comp_s2.tbat_below_hot;
        d.status.under_temperature_flag = q.comp_s2.tbat_above_cold;

        // fail-safe timer, halted in shutdown
        if (clr) begin
            d.cyc_cnt = '0;
            d.sec_cnt = '0;
            d.min_cnt = '0;
        end else if (!q.cmd.power_shutdown_bit && !hit) begin
            if (q.cyc_cnt == supervisor_pkg::CYC_W'(CYCLES_PER_SEC - 1)) begin
                d.cyc_cnt = '0;
                if (q.sec_cnt == 6'(supervisor_pkg::SECS_PER_MIN - 1)) begin
                    d.sec_cnt = '0;
                    d.min_cnt = q.min_cnt + 9'h001;
                end else begin
                    d.sec_cnt = q.sec_cnt + 6'h01;
                end
            end else begin
                d.cyc_cnt = q.cyc_cnt + 27'h0000001;
            end
        end
        // a set in the clearing cycle wins
        d.status.charge_time_expired_flag = hit | (q.status.charge_time_expired_flag & ~clr);
        d.status.failsafe_occurred_flag = fs_set | (q.status.failsafe_occurred_flag & ~clr);

        // serial command frame
        if (cs_high) begin
            d.frame = supervisor_pkg::FR_HUNT;
            d.bit_cnt = '0;
            d.tx_cnt = supervisor_pkg::TX_WAIT;
            d.oe = 1'b0;
            d.dout = 1'b0;
            d.cmd.failsafe_clear_bit = 1'b0;
        end else begin
            unique case (q.frame)
                supervisor_pkg::FR_HUNT: begin
                    // leading zeros are skipped until the start bit
                    if (ck_rise && q.di_s2) begin
                        d.frame = supervisor_pkg::FR_CMD;
                        d.bit_cnt = supervisor_pkg::BIT_ONE;
                    end
                end
                supervisor_pkg::FR_CMD: begin
                    if (ck_rise) begin
                        d.bit_cnt = nb;
                        // bits take effect as they arrive, so the mode acts early
                        case (nb)
                            supervisor_pkg::POS_OPERATING_SELECT_LO: d.cmd.operating_select_lo = q.di_s2;
                            supervisor_pkg::POS_OPERATING_SELECT_HI: d.cmd.operating_select_hi = q.di_s2;
                            supervisor_pkg::POS_PS: d.cmd.power_shutdown_bit = q.di_s2;
                            supervisor_pkg::POS_FAILSAFE_CLEAR_BIT: d.cmd.failsafe_clear_bit = q.di_s2;
                            supervisor_pkg::POS_TO0: d.cmd.timeout_sel_bit0 = q.di_s2;
                            supervisor_pkg::POS_TO1: d.cmd.timeout_sel_bit1 = q.di_s2;
                            supervisor_pkg::POS_TO2: d.cmd.timeout_sel_bit2 = q.di_s2;
                            supervisor_pkg::POS_VR0: d.cmd.loop_ref_sel_lo = q.di_s2;
                            supervisor_pkg::POS_VR1: d.cmd.loop_ref_sel_hi = q.di_s2;
                            default: ;
                        endcase
                        if (nb == supervisor_pkg::CMD_LAST) begin
                            d.frame = supervisor_pkg::FR_TX;
                            d.tx_sh = {adc_result, q.status};
                        end
                    end
                end
                supervisor_pkg::FR_TX: begin
                    // one idle period, a null bit, then data and zero fill
                    if (ck_fall) begin
                        unique case (q.tx_cnt)
                            supervisor_pkg::TX_WAIT: d.tx_cnt = supervisor_pkg::TX_NULL;
                            supervisor_pkg::TX_NULL: begin
                                d.tx_cnt = supervisor_pkg::TX_DATA;
                                d.oe = 1'b1;
                                d.dout = 1'b0;
                            end
                            default: begin
                                d.dout = q.tx_sh[supervisor_pkg::TX_W-1];
                                d.tx_sh = {q.tx_sh[supervisor_pkg::TX_W-2:0], 1'b0};
                            end
                        endcase
                    end
                end
                default: d.frame = supervisor_pkg::FR_HUNT;
            endcase
        end

        // loop and power controls
        d.power_on = ~q.cmd.power_shutdown_bit;
        d.drain = dis_mode & q.status.battery_present_flag & ~q.status.battery_reversed_flag
                & ~dis_fault & ~d.status.failsafe_occurred_flag;
        d.charge = chg_mode & q.status.battery_present_flag & ~q.status.battery_reversed_flag
                 & ~chg_fault & ~d.status.failsafe_occurred_flag;
        d.gauge = (mode == supervisor_pkg::MODE_GAUGE) & ~q.cmd.power_shutdown_bit;
        unique case (ref_code)
            2'h0: d.ref_mv = supervisor_pkg::REF_MV_00;
            2'h1: d.ref_mv = supervisor_pkg::REF_MV_01;
            2'h2: d.ref_mv = supervisor_pkg::REF_MV_10;
            2'h3: d.ref_mv = supervisor_pkg::REF_MV_11;
        endcase
    end

    // power-up clear: all command bits zero, serial lines idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.frame <= supervisor_pkg::FR_HUNT;
        end else begin
            q <= d;
        end
    end

    assign dout = q.dout;
    assign dout_oe = q.oe;
    assign fault_status_word = q.status;
    assign battery_drain_drive = q.drain;
    assign charge_loop_enable = q.charge;
    assign gas_gauge_enable = q.gauge;
    assign analog_power_on = q.power_on;
    assign loop_ref_mv = q.ref_mv;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_present_steady;
        comp_i.vbat_below_present [*3];
    endsequence

    sequence s_end_steady;
        comp_i.cell_below_end [*3];
    endsequence

    sequence s_operating_select_lo_slot;
        (q.frame == supervisor_pkg::FR_CMD) && ck_rise && (q.bit_cnt == supervisor_pkg::BIT_ONE) && !cs_high;
    endsequence

    sequence s_select_idle;
        cs_n [*3];
    endsequence

    sequence s_operating_select_hi_slot;
        (q.frame == supervisor_pkg::FR_CMD) && ck_rise && (q.bit_cnt == supervisor_pkg::POS_OPERATING_SELECT_LO) && !cs_high;
    endsequence

    // three steady edges: two synchroniser stages plus the status stage
    sequence s_reverse_steady;
        comp_i.cell_below_reverse [*3];
    endsequence

    sequence s_max_steady;
        comp_i.cell_above_max [*3];
    endsequence

    sequence s_hot_steady;
        comp_i.tbat_below_hot [*3];
    endsequence

    sequence s_absent_steady;
        !comp_i.vbat_below_present [*3];
    endsequence

    AST_REF_LOW: assert property (ref_code == 2'h0 |=> loop_ref_mv == supervisor_pkg::REF_MV_00)
        else $error("reference level wrong for code 0");
    AST_REF_HIGH: assert property (ref_code == 2'h3 |=> loop_ref_mv == supervisor_pkg::REF_MV_11)
        else $error("reference level wrong for code 3");
    AST_PRESENT: assert property (s_present_steady |=> fault_status_word.battery_present_flag)
        else $error("present comparator not reflected");
    AST_END_FLAG: assert property (s_end_steady |=> fault_status_word.end_discharge_flag)
        else $error("end of discharge comparator not reflected");
    AST_COLD: assert property (!comp_i.tbat_above_cold [*3] |=> !fault_status_word.under_temperature_flag)
        else $error("cold flag set without cause");
    AST_TIMEOUT: assert property ($rose(fault_status_word.charge_time_expired_flag) |-> $past(hit))
        else $error("timeout flag rose before limit");
    AST_FS_DRAIN: assert property (
        dis_mode && q.status.end_discharge_flag |=> fault_status_word.failsafe_occurred_flag)
        else $error("discharge fault did not set fail-safe");
    AST_FS_CHARGE: assert property (
        chg_mode && q.status.max_cell_voltage_flag |=> fault_status_word.failsafe_occurred_flag)
        else $error("charge fault did not set fail-safe");
    AST_FS_HOLD: assert property (
        fault_status_word.failsafe_occurred_flag && !clr |=> fault_status_word.failsafe_occurred_flag)
        else $error("fail-safe flag dropped without clear");
    AST_DRAIN_BLOCK: assert property (dis_fault || !q.status.battery_present_flag |=> !battery_drain_drive)
        else $error("drain driven during fault");
    AST_SHUTDOWN: assert property (
        q.cmd.power_shutdown_bit |=> !analog_power_on && !battery_drain_drive && !charge_loop_enable)
        else $error("shutdown left circuits on");
    AST_IDLE: assert property (
        mode == supervisor_pkg::MODE_IDLE |=> !battery_drain_drive && !charge_loop_enable && !gas_gauge_enable)
        else $error("idle mode left a function on");
    AST_MODE_EARLY: assert property (s_operating_select_lo_slot |=> q.cmd.operating_select_lo == $past(q.di_s2))
        else $error("mode bit not applied on arrival");
    AST_DRAIN_ON: assert property (
        dis_mode && q.status.battery_present_flag && !q.status.battery_reversed_flag && !dis_fault
        && !fault_status_word.failsafe_occurred_flag |=> battery_drain_drive)
        else $error("drain not driven in clean discharge");
    AST_CLEAR_DROP: assert property (s_select_idle |=> !clr)
        else $error("clear bit survived select high");
    AST_TIMER_ZERO: assert property (clr |=> q.min_cnt == '0 && q.sec_cnt == '0)
        else $error("timer not held at zero by clear");
    AST_REF_MID_LO: assert property (ref_code == 2'h1 |=> loop_ref_mv == supervisor_pkg::REF_MV_01)
        else $error("reference level wrong for code 1");
    AST_REF_MID_HI: assert property (ref_code == 2'h2 |=> loop_ref_mv == supervisor_pkg::REF_MV_10)
        else $error("reference level wrong for code 2");
    AST_ABSENT: assert property (s_absent_steady |=> !fault_status_word.battery_present_flag)
        else $error("removed battery still shown present");
    AST_REVERSED: assert property (s_reverse_steady |=> fault_status_word.battery_reversed_flag)
        else $error("reverse comparator not reflected");
    AST_MAX_CELL: assert property (s_max_steady |=> fault_status_word.max_cell_voltage_flag)
        else $error("max cell comparator not reflected");
    AST_HOT: assert property (s_hot_steady |=> fault_status_word.over_temperature_flag)
        else $error("hot comparator not reflected");
    AST_TIMEOUT_SET: assert property (hit |=> fault_status_word.charge_time_expired_flag)
        else $error("timeout flag missing at limit");
    // a fault present in the clearing cycle re-sets the flag, so only a clean clear is checked
    AST_FS_CLEAR: assert property (clr && !fs_set |=> !fault_status_word.failsafe_occurred_flag)
        else $error("fail-safe flag survived clear");
    AST_FS_BLOCK: assert property (
        fault_status_word.failsafe_occurred_flag && !clr |=> !battery_drain_drive && !charge_loop_enable)
        else $error("loop running with fail-safe set");
    AST_CHARGE_BLOCK: assert property (
        chg_fault || q.status.battery_reversed_flag |=> !charge_loop_enable)
        else $error("charge driven during fault");
    AST_GAUGE: assert property (
        mode == supervisor_pkg::MODE_GAUGE && !q.cmd.power_shutdown_bit |=> gas_gauge_enable)
        else $error("gauge mode not entered");
    AST_POWER_ON: assert property (!q.cmd.power_shutdown_bit |=> analog_power_on)
        else $error("analog power off outside shutdown");
    AST_MODE_EARLY_HI: assert property (s_operating_select_hi_slot |=> q.cmd.operating_select_hi == $past(q.di_s2))
        else $error("upper mode bit not applied on arrival");
    // the output driver must let go once the frame is over
    AST_OE_DROP: assert property (s_select_idle |=> !dout_oe)
        else $error("data output still driven after select high");

endmodule : battery_fault_supervisor

// ### supervisor_pkg.sv
package supervisor_pkg;

    // serial command word
    localparam logic [4:0] CMD_LAST = 5'h16;
    localparam logic [4:0] POS_OPERATING_SELECT_LO = 5'h02;
    localparam logic [4:0] POS_OPERATING_SELECT_HI = 5'h03;
    localparam logic [4:0] POS_PS = 5'h0D;
    localparam logic [4:0] POS_FAILSAFE_CLEAR_BIT = 5'h11;
    localparam logic [4:0] POS_TO0 = 5'h12;
    localparam logic [4:0] POS_TO1 = 5'h13;
    localparam logic [4:0] POS_TO2 = 5'h14;
    localparam logic [4:0] POS_VR0 = 5'h15;
    localparam logic [4:0] POS_VR1 = 5'h16;
    localparam logic [4:0] BIT_ONE = 5'h01;

    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_DRAIN = 2'h1;
    localparam logic [1:0] MODE_CHARGE = 2'h2;
    localparam logic [1:0] MODE_GAUGE = 2'h3;

    // charge loop reference levels in millivolts
    localparam logic [7:0] REF_MV_00 = 8'h12;
    localparam logic [7:0] REF_MV_01 = 8'h22;
    localparam logic [7:0] REF_MV_10 = 8'h37;
    localparam logic [7:0] REF_MV_11 = 8'hA0;

    // fail-safe timer
    localparam int CLK_PERIOD_NS = 10;
    localparam int NS_PER_SEC = 1000000000;
    localparam int CYCLES_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
    localparam int SECS_PER_MIN = 60;
    localparam int CYC_W = 27;
    localparam int MIN_W = 9;
    localparam logic [MIN_W-1:0] TIMEOUT_BASE_MIN = 9'h005;
    localparam logic [2:0] TO_NONE = 3'h7;

    localparam logic [1:0] TX_WAIT = 2'h0;
    localparam logic [1:0] TX_NULL = 2'h1;
    localparam logic [1:0] TX_DATA = 2'h2;
    localparam int TX_W = 18;

    typedef enum logic [2:0] {
        FR_HUNT = 3'h1,
        FR_CMD = 3'h2,
        FR_TX = 3'h4
    } frame_t;

    typedef struct packed {
        logic loop_ref_sel_hi;
        logic loop_ref_sel_lo;
        logic timeout_sel_bit2;
        logic timeout_sel_bit1;
        logic timeout_sel_bit0;
        logic failsafe_clear_bit;
        logic power_shutdown_bit;
        logic operating_select_hi;
        logic operating_select_lo;
    } cmd_t;

    // bit 1 of the word is the lsb
    typedef struct packed {
        logic failsafe_occurred_flag;
        logic charge_time_expired_flag;
        logic under_temperature_flag;
        logic over_temperature_flag;
        logic end_discharge_flag;
        logic max_cell_voltage_flag;
        logic battery_reversed_flag;
        logic battery_present_flag;
    } status_t;

    // raw comparator outputs, asynchronous to clk
    typedef struct packed {
        logic tbat_above_cold;
        logic tbat_below_hot;
        logic cell_below_end;
        logic cell_above_max;
        logic cell_below_reverse;
        logic vbat_below_present;
    } comp_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic ck_s1;
        logic ck_s2;
        logic ck_prev;
        logic di_s1;
        logic di_s2;
        comp_t comp_s1;
        comp_t comp_s2;
        frame_t frame;
        logic [4:0] bit_cnt;
        cmd_t cmd;
        logic [1:0] tx_cnt;
        logic [TX_W-1:0] tx_sh;
        logic dout;
        logic oe;
        status_t status;
        logic [CYC_W-1:0] cyc_cnt;
        logic [5:0] sec_cnt;
        logic [MIN_W-1:0] min_cnt;
        logic drain;
        logic charge;
        logic gauge;
        logic power_on;
        logic [7:0] ref_mv;
    } state_t;

endpackage : supervisor_pkg

// ### host_link_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////
module host_link_model (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    // link clock rests low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    // half of the 160 ns link period, launched just after a clk edge
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask : half

    // a frame shorter than 22 bits is aborted by chip select, with no readback
    task automatic xfer(input supervisor_pkg::cmd_t c, input int nbits, output logic [19:0] rd);
        logic [22:1] w;
        int last;
        w = {c.loop_ref_sel_hi, c.loop_ref_sel_lo, c.timeout_sel_bit2, c.timeout_sel_bit1, c.timeout_sel_bit0,
             c.failsafe_clear_bit, 3'h0, c.power_shutdown_bit, 9'h000,
             c.operating_select_hi, c.operating_select_lo, 1'b1};
        last = (nbits < 22) ? nbits : nbits + 20;
        rd = '0;
        cs_n = 1'b0;
        for (int i = 1; i <= last; i++) begin
            // din is idle during readback, so it toggles rather than hold a stale bit
            din = (i <= nbits) ? w[i] : ~din;
            half();
            sclk = 1'b1;
            if (i == nbits + 1) rd[19] = dout_oe;
            if (i == nbits + 2) rd[18] = dout_oe & ~dout;
            if (i > nbits + 2) rd[nbits + 20 - i] = dout;
            half();
            sclk = 1'b0;
        end
        half();
        cs_n = 1'b1;
        din = ~din;
        half();
    endtask : xfer
endmodule : host_link_model

// ### tb_top.sv
`timescale 1ns/100ps
////////////////////////////////////////////////
module tb_top;
    typedef struct packed {
        logic kind;
        logic [19:0] val;
    } note_t;

    localparam logic [5:0] FAULT_LIST [6] = '{6'h00, 6'h03, 6'h05, 6'h09, 6'h11, 6'h21};
    localparam logic [7:0] REF_LEVELS [4] = '{8'h12, 8'h22, 8'h37, 8'hA0};

    logic clk, rst_n, cs_n, sclk, din, dout, dout_oe;
    logic drain, chg, gauge, pwr, probe;
    logic [7:0] ref_mv;
    logic [9:0] adc;
    logic [19:0] rd;
    supervisor_pkg::comp_t comp;
    supervisor_pkg::status_t stat;
    logic [1:0] mode_e, vr_e;
    logic ps_e, fs_e, charge_time_expired_flag_e;
    note_t q[$];
    note_t nt;
    int fail_count, total_checks;
    int unsigned seed;

    always #5 clk = ~clk;

    battery_fault_supervisor #(.CYCLES_PER_SEC(10)) battery_fault_supervisor_inst (
        .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
        .comp_i(comp), .adc_result(adc), .fault_status_word(stat), .battery_drain_drive(drain),
        .charge_loop_enable(chg), .gas_gauge_enable(gauge), .analog_power_on(pwr), .loop_ref_mv(ref_mv)
    );

    host_link_model host_link_model_inst (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe)
    );

    ////////////////////////////////////////////////
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    // port view: status, drain, charge, gauge, power, reference level
    function automatic logic [19:0] port_exp();
        logic blk;
        blk = !comp[0] | comp[1] | comp[4] | comp[5] | charge_time_expired_flag_e | fs_e | ps_e;
        return {fs_e, charge_time_expired_flag_e, comp, mode_e == supervisor_pkg::MODE_DRAIN && !blk && !comp[3],
                mode_e == supervisor_pkg::MODE_CHARGE && !blk && !comp[2],
                mode_e == supervisor_pkg::MODE_GAUGE && !ps_e, !ps_e, REF_LEVELS[vr_e]};
    endfunction : port_exp

    task automatic pulse();
        probe = 1'b1;
        @(posedge clk);
        #1;
        probe = 1'b0;
    endtask : pulse

    // six cycles cover the synchroniser plus the latch stage
    task automatic look();
        logic hot_cold;
        repeat (6) @(posedge clk);
        #1;
        hot_cold = comp[4] | comp[5] | charge_time_expired_flag_e;
        if (!ps_e && mode_e == supervisor_pkg::MODE_DRAIN && (hot_cold | comp[3])) fs_e = 1'b1;
        if (!ps_e && mode_e == supervisor_pkg::MODE_CHARGE && (hot_cold | comp[2])) fs_e = 1'b1;
        q.push_back({1'b0, port_exp()});
        pulse();
    endtask : look

    // every full frame carries the clear bit, so each one restarts the timer
    task automatic send(input logic [1:0] m, input logic ps, input logic [2:0] to, input logic [1:0] vr,
                        input int nbits);
        adc = 10'($urandom);
        host_link_model_inst.xfer({vr, to, 1'b1, ps, m}, nbits, rd);
        mode_e = m;
        if (nbits == 22) begin
            {ps_e, vr_e, fs_e, charge_time_expired_flag_e} = {ps, vr, 2'b00};
            if (!ps) begin
                q.push_back({1'b1, 2'b01, adc, fs_e, charge_time_expired_flag_e, comp});
                pulse();
            end
        end
        look();
    endtask : send

    always @(posedge clk) begin
        if (probe) begin
            nt = q.pop_front();
            if (nt.kind) check(rd, nt.val);
            else check({stat, drain, chg, gauge, pwr, ref_mv}, nt.val);
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        test_done();
    end

    ////////////////////////////////////////////////
    initial begin
        seed = $urandom(32'h5C7B);
        clk = 1'b0;
        rst_n = 1'b0;
        comp = 6'h01;
        adc = '0;
        probe = 1'b0;
        {mode_e, vr_e, ps_e, fs_e, charge_time_expired_flag_e} = '0;
        fail_count = 0;
        total_checks = 0;
        repeat (10) @(posedge clk);
        #1;
        q.push_back('0);
        pulse();
        rst_n = 1'b1;
        look();
        for (int v = 0; v < 4; v++) send(supervisor_pkg::MODE_IDLE, 1'b0, 3'h7, 2'(v), 22);
        for (int i = 0; i < 6; i++) begin
            comp = 6'($urandom);
            look();
        end
        comp = 6'h01;
        // mode bits act before the frame ends
        send(supervisor_pkg::MODE_DRAIN, 1'b0, 3'h0, 2'h0, 3);
        for (int m = 1; m < 3; m++) begin
            send(2'(m), 1'b0, 3'h7, 2'h2, 22);
            for (int k = 0; k < 6; k++) begin
                comp = FAULT_LIST[k];
                look();
                comp = 6'h01;
                look();
                send(2'(m), 1'b0, 3'h7, 2'h2, 22);
            end
        end
        send(supervisor_pkg::MODE_GAUGE, 1'b0, 3'h7, 2'h3, 22);
        send(supervisor_pkg::MODE_IDLE, 1'b0, 3'h7, 2'h1, 22);
        comp = 6'h00;
        send(supervisor_pkg::MODE_DRAIN, 1'b1, 3'h7, 2'h1, 22);
        comp = 6'h01;
        send(supervisor_pkg::MODE_DRAIN, 1'b0, 3'h0, 2'h0, 22);
        // margins allow the timer restart anywhere between the clear bit and chip select high
        repeat (2400) @(posedge clk);
        look();
        repeat (900) @(posedge clk);
        charge_time_expired_flag_e = 1'b1;
        look();
        send(supervisor_pkg::MODE_IDLE, 1'b0, 3'h1, 2'h0, 22);
        repeat (5400) @(posedge clk);
        look();
        repeat (900) @(posedge clk);
        charge_time_expired_flag_e = 1'b1;
        look();
        send(supervisor_pkg::MODE_IDLE, 1'b0, 3'h7, 2'h0, 22);
        repeat (6600) @(posedge clk);
        look();
        test_done();
    end
endmodule : tb_top
